// ===== src/stage_seq_pkg.sv
// Shared constants and carrier types of the stage program sequencer
package stage_seq_pkg;

  // Stage table shape
  localparam int STAGES       = 16;
  localparam int STAGE_IDX_W  = 4;
  localparam int FREQ_W       = 16;   // 0.01 Hz units
  localparam int TIME_W       = 16;   // 0.1 s units
  localparam int MODE_W       = 3;

  // Setting limits, in setting units
  localparam logic [FREQ_W-1:0] FREQ_MAX = 16'h9C40;  // 400.00 Hz
  localparam logic [TIME_W-1:0] TIME_MAX = 16'hEA60;  // 6000.0 s

  // Direction codes per stage
  localparam logic [1:0] DIR_STOP = 2'h0;
  localparam logic [1:0] DIR_FWD  = 2'h1;
  localparam logic [1:0] DIR_REV  = 2'h2;

  // Mode codes
  localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;

  // Run timer tick: 0.1 s of a 100 MHz clock
  localparam int CLK_HZ        = 100_000_000;
  localparam int TICK_MS       = 100;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W        = 24;

  // Reset values
  localparam logic [STAGE_IDX_W-1:0] STAGE_RST = 4'h0;
  localparam logic [TIME_W-1:0]      TIME_RST  = 16'h0000;

  // Output carrier toward the speed reference path
  typedef struct packed {
    logic              active;
    logic [FREQ_W-1:0] freq;
    logic [1:0]        dir;
    logic              run;
  } seq_ref_t;

  // Sequencer phase
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_RUN,
    PH_HOLD,
    PH_DONE
  } seq_phase_t;

endpackage : stage_seq_pkg

// ===== src/tick_gen.sv
// Periodic tick generator for the stage run timer
`timescale 1ns/1ps
`default_nettype none
module tick_gen
  import stage_seq_pkg::*;
#(
  parameter int PERIOD = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Control
  input  wire logic enable,
  // Tick out
  output logic      tick
);

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              tick;
  } tick_state_t;

  tick_state_t s_reg;
  tick_state_t s_next;

  // Count while enabled; holding the count keeps partial ticks across a stop
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (enable) begin
      if (s_reg.cnt == TICK_W'(PERIOD - 1)) begin
        s_next.cnt = '0;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule : tick_gen
`default_nettype wire

// ===== src/stage_program_sequencer.sv
// Automatic stage program sequencer of a motor drive
// Operation
// (RULE_01) Modes 1 and 4 run the stage sequence once.
// (RULE_02) Modes 2 and 5 repeat the stage sequence continuously.
// (RULE_03) Modes 3 and 6 run once then hold last stage speed.
// (RULE_04) Modes 1 to 3 resume the unfinished stage after a stop.
// (RULE_05) Modes 4 to 6 restart at stage zero after a stop.
// (RULE_06) Mode zero disables the sequencer; normal reference is used.
// (RULE_07) Wobble or PID enabled forces the sequencer inactive.
// (RULE_08) Sequencer inactive when all stage run times are zero.
// (RULE_09) Multi-step speed inputs are ignored while sequencer is enabled.
// (RULE_10) Stage zero frequency comes from multi-speed zero setting.
// (RULE_11) Automatic operation selects primary accel and decel times.
// (RULE_12) Stages 1 to 15 hold frequency, 0.00 to 400.00 Hz.
// (RULE_13) Stages 0 to 15 hold run time, 0.0 to 6000.0 s.
// (RULE_14) Direction code: 0 stop, 1 forward, 2 reverse.
// (RULE_15) Single cycle stops output after last stage time expires.
// (RULE_16) Continuous mode wraps from last stage back to zero.
// (RULE_17) Stages advance ascending, each shown for its run time.
// (RULE_18) Stage timer counts 0.1 s ticks, cleared on stage entry.
// (RULE_19) Stop halts timer, keeping stage index and elapsed time; both are kept only when stopped while running in modes 1 to 3.
`timescale 1ns/1ps
`default_nettype none
module stage_program_sequencer
  import stage_seq_pkg::*;
#(
  parameter int N_STAGES   = STAGES,
  parameter int TICK_COUNT = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // Settings
  input  wire logic [MODE_W-1:0]            mode,
  input  wire logic                         wobble_en,
  input  wire logic                         pid_en,
  input  wire logic [FREQ_W-1:0]            speed0_freq,
  input  wire logic [N_STAGES*FREQ_W-1:0]   stage_freq,
  input  wire logic [N_STAGES*TIME_W-1:0]   stage_time,
  input  wire logic [N_STAGES*2-1:0]        stage_dir,
  // Operation control
  input  wire logic                         run_cmd,
  // Multi-step speed selection from terminals
  input  wire logic [3:0]                   mstep_in,
  // Speed reference path
  output var  seq_ref_t                     ref_out,
  output logic [3:0]                        mstep_out,
  output logic                              use_primary_ramp,
  output logic [STAGE_IDX_W-1:0]            stage_idx,
  output logic                              cycle_done
);

  typedef struct packed {
    seq_phase_t             phase;
    logic [STAGE_IDX_W-1:0] idx;
    logic [TIME_W-1:0]      elapsed;
    logic                   run_d;
    seq_ref_t               ref_o;
    logic [3:0]             mstep;
    logic                   prim;
    logic                   done;
  } seq_state_t;

  seq_state_t s_reg;
  seq_state_t s_next;

  // Checks below share this clock and reset
  default clocking cb_seq @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic       tick;
  logic       enabled;
  logic       any_time;
  logic       mode_once;
  logic       mode_loop;
  logic       mode_hold;
  logic       mode_resume;
  logic [FREQ_W-1:0] freq_arr [N_STAGES];
  logic [TIME_W-1:0] time_arr [N_STAGES];
  logic [1:0]        dir_arr  [N_STAGES];
  logic [N_STAGES-1:0] time_nz;

  // Unpack stage tables; stage 0 frequency from multi-speed zero
  for (genvar g = 0; g < N_STAGES; g++) begin : g_stage
    if (g == 0) begin : g_s0
      assign freq_arr[g] = speed0_freq; // RULE_10
    end else begin : g_sn
      // Clamp to 400.00 Hz
      assign freq_arr[g] = (stage_freq[g*FREQ_W +: FREQ_W] > FREQ_MAX) ?
                           FREQ_MAX : stage_freq[g*FREQ_W +: FREQ_W]; // RULE_12
    end
    // Clamp to 6000.0 s
    assign time_arr[g] = (stage_time[g*TIME_W +: TIME_W] > TIME_MAX) ?
                         TIME_MAX : stage_time[g*TIME_W +: TIME_W]; // RULE_13
    assign dir_arr[g]  = stage_dir[g*2 +: 2];
    assign time_nz[g]  = (time_arr[g] != TIME_RST);
  end

  // Mode decode
  assign mode_once   = (mode == 3'h1) || (mode == 3'h4); // RULE_01
  assign mode_loop   = (mode == 3'h2) || (mode == 3'h5); // RULE_02
  assign mode_hold   = (mode == 3'h3) || (mode == 3'h6); // RULE_03
  assign mode_resume = (mode >= 3'h1) && (mode <= 3'h3); // RULE_04
  assign any_time    = |time_nz; // RULE_08
  // Wobble or PID override any mode; mode 0 or 7 is off
  assign enabled = (mode_once || mode_loop || mode_hold) && !wobble_en &&
                   !pid_en && any_time; // RULE_06 RULE_07

  // Tick only while a stage is actually running
  tick_gen #(
    .PERIOD (TICK_COUNT)
  ) u_tick (
    .clk    (clk),
    .rstn   (rstn),
    .enable (enabled && run_cmd && s_reg.phase == PH_RUN),
    .tick   (tick)
  );

  // Sequencer next state
  always_comb begin
    s_next = s_reg;
    s_next.run_d = run_cmd;
    s_next.done = 1'b0;
    // Terminal multi-step inputs masked while enabled
    s_next.mstep = enabled ? 4'h0 : mstep_in; // RULE_09
    s_next.prim = enabled; // RULE_11
    if (!enabled) begin
      // Disabled: start fresh when re-enabled
      s_next.phase = PH_IDLE; // RULE_06
      s_next.idx = STAGE_RST;
      s_next.elapsed = TIME_RST;
    end else begin
      unique case (s_reg.phase)
        PH_IDLE: begin
          if (run_cmd) begin
            s_next.phase = PH_RUN;
          end
        end
        PH_RUN: begin
          if (!run_cmd) begin
            // Timer halts; index and elapsed kept in modes 1 to 3, reset in modes 4 to 6
            s_next.phase = PH_IDLE; // RULE_19
            if (!mode_resume) begin
              s_next.idx = STAGE_RST; // RULE_05
              s_next.elapsed = TIME_RST;
            end
          end else if (s_reg.elapsed >= time_arr[s_reg.idx]) begin
            // Stage time over; next stage starts with a cleared timer
            s_next.elapsed = TIME_RST; // RULE_18
            if (s_reg.idx == STAGE_IDX_W'(N_STAGES - 1)) begin
              if (mode_loop) begin
                s_next.idx = STAGE_RST; // RULE_16
              end else if (mode_hold) begin
                s_next.phase = PH_HOLD; // RULE_03
                s_next.done = 1'b1;
              end else begin
                s_next.phase = PH_DONE; // RULE_15
                s_next.done = 1'b1;
              end
            end else begin
              s_next.idx = s_reg.idx + 1'b1; // RULE_17
            end
          end else if (tick) begin
            s_next.elapsed = s_reg.elapsed + 1'b1; // RULE_18
          end
        end
        PH_HOLD: begin
          if (!run_cmd) begin
            s_next.phase = PH_IDLE;
            s_next.idx = STAGE_RST;
            s_next.elapsed = TIME_RST;
          end
        end
        PH_DONE: begin
          // Cycle complete; a fresh run command starts a new cycle
          if (!run_cmd) begin
            s_next.phase = PH_IDLE;
            s_next.idx = STAGE_RST;
            s_next.elapsed = TIME_RST;
          end
        end
      endcase
    end
    // Reference toward the ramp path
    s_next.ref_o.active = enabled;
    s_next.ref_o.freq = freq_arr[s_next.idx];
    s_next.ref_o.dir = dir_arr[s_next.idx]; // RULE_14
    s_next.ref_o.run = enabled && run_cmd &&
                       (s_next.phase == PH_RUN || s_next.phase == PH_HOLD) &&
                       (dir_arr[s_next.idx] != DIR_STOP); // RULE_14
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ref_out          = s_reg.ref_o;
  assign mstep_out        = s_reg.mstep;
  assign use_primary_ramp = s_reg.prim;
  assign stage_idx        = s_reg.idx;
  assign cycle_done       = s_reg.done;

  // Checks
  a_off_inactive: assert property ( // RULE_07
    (wobble_en || pid_en) |=> !ref_out.active)
    else $error("sequencer active with wobble or pid");

  a_mode_zero: assert property ( // RULE_06
    (mode == MODE_OFF) |=> !ref_out.active && !ref_out.run)
    else $error("sequencer active in mode zero");

  a_zero_times: assert property ( // RULE_08
    !any_time |=> !ref_out.active)
    else $error("sequencer active with zero times");

  a_mstep_mask: assert property ( // RULE_09 RULE_11
    enabled |=> mstep_out == 4'h0 && use_primary_ramp)
    else $error("multi-step not masked");

  a_stop_keeps: assert property ( // RULE_19
    (s_reg.phase == PH_IDLE && enabled && !run_cmd && !$past(run_cmd))
    |=> $stable(stage_idx))
    else $error("stage index moved while stopped");

  a_restart_zero: assert property ( // RULE_05
    (s_reg.phase == PH_RUN && !run_cmd && enabled && !mode_resume)
    |=> stage_idx == STAGE_RST)
    else $error("no restart from stage zero");

  // Last stage running out of time with the run command still applied
  sequence s_last_expire;
    s_reg.phase == PH_RUN && run_cmd && enabled &&
    s_reg.idx == STAGE_IDX_W'(N_STAGES - 1) &&
    s_reg.elapsed >= time_arr[s_reg.idx];
  endsequence

  a_loop_wrap: assert property ( // RULE_16
    mode_loop ##0 s_last_expire |=> stage_idx == STAGE_RST)
    else $error("continuous mode did not wrap");

  a_once_stop: assert property ( // RULE_15
    mode_once ##0 s_last_expire |=> cycle_done ##1 !ref_out.run)
    else $error("single cycle did not stop");

  a_hold_last: assert property ( // RULE_03
    mode_hold ##0 s_last_expire |=> s_reg.phase == PH_HOLD &&
    stage_idx == STAGE_IDX_W'(N_STAGES - 1))
    else $error("hold mode left last stage");

  a_advance: assert property ( // RULE_17 RULE_18
    (s_reg.phase == PH_RUN && run_cmd && enabled &&
     s_reg.idx != STAGE_IDX_W'(N_STAGES - 1) &&
     s_reg.elapsed >= time_arr[s_reg.idx])
    |=> stage_idx == $past(stage_idx) + 1'b1 && s_reg.elapsed == TIME_RST)
    else $error("stage did not advance");

endmodule : stage_program_sequencer
`default_nettype wire

// ===== dv/drive_cmd_model.sv
// Run command source and speed reference follower of the drive
`timescale 1ns/1ps
`default_nettype none
module drive_cmd_model
  import stage_seq_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // Operator request and reference in
  input  wire logic          go,
  input  wire seq_ref_t      ref_in,
  // Run command out, last followed speed
  output logic               run_cmd,
  output logic [FREQ_W-1:0]  speed_reg
);
  // Switch registered like a filtered terminal; speed kept while stopped
  always_ff @(posedge clk) begin
    run_cmd   <= rstn & go;
    speed_reg <= !rstn ? 16'h0000 : ref_in.run ? ref_in.freq : speed_reg;
  end
endmodule : drive_cmd_model
`default_nettype wire

// ===== dv/tb_stage_program_sequencer.sv
// Self-checking bench of the stage program sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_stage_program_sequencer;
  import stage_seq_pkg::*;
  localparam int TK = 4;
  // Stage times in ticks: 2, 1, 3, twelve empty stages, then 8
  localparam logic [255:0] TIMES =
    256'h0008000000000000000000000000000000000000000000000000000300010002;
  logic clk, rstn, wobble_en, pid_en, go, run_cmd;
  logic use_primary_ramp, cycle_done;
  logic [2:0] mode;
  logic [15:0] speed0_freq, speed_reg;
  logic [255:0] stage_freq, stage_time;
  logic [31:0] stage_dir;
  logic [3:0] mstep_in, mstep_out, stage_idx;
  seq_ref_t ref_out;
  int err_count, checks;

  stage_program_sequencer #(.TICK_COUNT(TK)) i_dut (.clk(clk), .rstn(rstn),
    .mode(mode), .wobble_en(wobble_en), .pid_en(pid_en),
    .speed0_freq(speed0_freq), .stage_freq(stage_freq),
    .stage_time(stage_time), .stage_dir(stage_dir), .run_cmd(run_cmd),
    .mstep_in(mstep_in), .ref_out(ref_out), .mstep_out(mstep_out),
    .use_primary_ramp(use_primary_ramp), .stage_idx(stage_idx),
    .cycle_done(cycle_done));
  drive_cmd_model i_drv (.clk(clk), .rstn(rstn), .go(go), .ref_in(ref_out),
    .run_cmd(run_cmd), .speed_reg(speed_reg));

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Bounded wait for a stage index
  task automatic wait_idx(input logic [3:0] i);
    int n;
    n = 0;
    while (stage_idx !== i && n < 300) begin
      cyc(1);
      n++;
    end
    chk({12'h000, stage_idx}, {12'h000, i});
  endtask : wait_idx

  task automatic set_go(input logic v, input logic [2:0] m);
    @(posedge clk);
    go   <= v;
    mode <= m;
    cyc(3);
  endtask : set_go

  task automatic do_reset();
    @(posedge clk);
    rstn <= 1'b0;
    go   <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    cyc(2);
  endtask : do_reset

  // Disabling conditions: mode 0, mode 7, wobble, PID, all times zero
  task automatic test_off();
    for (int k = 0; k < 5; k++) begin
      do_reset();
      @(posedge clk);
      wobble_en  <= (k == 2);
      pid_en     <= (k == 3);
      stage_time <= (k == 4) ? 256'h0 : TIMES;
      set_go(1'b1, (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : 3'h1);
      cyc(20);
      chk({14'h0, ref_out.active, ref_out.run}, '0);
      chk({15'h0, use_primary_ramp}, 16'h0000);
      chk({12'h0, mstep_out}, {12'h0, mstep_in});
      @(posedge clk);
      wobble_en  <= 1'b0;
      pid_en     <= 1'b0;
      stage_time <= TIMES;
    end
    $display("test_off done");
  endtask : test_off

  // Single cycle: stage values, order, timing, stop at end
  task automatic test_single();
    int n;
    do_reset();
    set_go(1'b1, 3'h1);
    wait_idx(4'h0);
    chk(ref_out.freq, speed0_freq);
    chk({14'h0, ref_out.dir}, {14'h0, DIR_FWD});
    chk({14'h0, ref_out.active, use_primary_ramp}, 16'h0003);
    chk({12'h0, mstep_out}, 16'h0000);
    n = 0;
    while (stage_idx === 4'h0 && n < 50) begin
      cyc(1);
      n++;
    end
    chk({15'h0, n >= 2 * TK - 2 && n <= 2 * TK + 2}, 16'h1);
    wait_idx(4'h1);
    chk(ref_out.freq, 16'h1111);
    chk({14'h0, ref_out.dir}, {14'h0, DIR_REV});
    wait_idx(4'h2);
    chk(ref_out.freq, FREQ_MAX);
    wait_idx(4'hF);
    chk(ref_out.freq, 16'h0FA0);
    n = 0;
    while (cycle_done !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk({15'h0, cycle_done}, 16'h0001);
    cyc(3);
    chk({15'h0, ref_out.run}, 16'h0000);
    set_go(1'b0, 3'h1);
    $display("test_single done");
  endtask : test_single

  // Continuous: wraps from last stage to stage zero still running
  task automatic test_loop();
    do_reset();
    set_go(1'b1, 3'h5);
    wait_idx(4'hF);
    wait_idx(4'h0);
    chk({15'h0, ref_out.run}, 16'h0001);
    chk(ref_out.freq, speed0_freq);
    wait_idx(4'h1);
    set_go(1'b0, 3'h5);
    $display("test_loop done");
  endtask : test_loop

  // Hold: after the cycle the drive keeps the last stage speed
  task automatic test_hold();
    do_reset();
    set_go(1'b1, 3'h6);
    wait_idx(4'hF);
    cyc(40);
    chk({11'h0, stage_idx, ref_out.run}, 16'h001F);
    chk(speed_reg, 16'h0FA0);
    set_go(1'b0, 3'h6);
    $display("test_hold done");
  endtask : test_hold

  // Stop in mid stage two, then run again in every active mode
  task automatic test_resume();
    int n;
    for (int m = 1; m < 7; m++) begin
      do_reset();
      set_go(1'b1, m[2:0]);
      wait_idx(4'h2);
      cyc(5);
      set_go(1'b0, m[2:0]);
      chk({15'h0, ref_out.run}, 16'h0000);
      set_go(1'b1, m[2:0]);
      chk({12'h0, stage_idx}, (m < 4) ? 16'h2 : 16'h0);
      // Kept elapsed time ends stage two early; a restart replays 0 to 2
      n = 0;
      while (stage_idx !== 4'h3 && n < 100) begin
        cyc(1);
        n++;
      end
      chk({12'h0, stage_idx}, 16'h0003);
      chk({15'h0, (m < 4) == (n <= 2 * TK + 2)}, 16'h1);
    end
    $display("test_resume done");
  endtask : test_resume

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #500000;
    err_count++;
    complete_run();
  end

  // Stage table: times in ticks, stages 3 to 14 zero length
  initial begin
    rstn = 1'b0;
    go = 1'b0;
    mode = 3'h0;
    wobble_en = 1'b0;
    pid_en = 1'b0;
    mstep_in = 4'hA;
    speed0_freq = 16'h05DC;
    stage_freq = {16'h0FA0, 192'h0, 16'hFFFF, 16'h1111, 16'hFFFF};
    stage_time = TIMES;
    stage_dir = {2'h2, 24'h0, 2'h1, 2'h2, 2'h1};
    err_count = 0;
    checks = 0;
    cyc(4);
    test_off();
    test_single();
    test_loop();
    test_hold();
    test_resume();
    complete_run();
  end
endmodule : tb_stage_program_sequencer
`default_nettype wire
